// >>> hw/ppx_map.vh
// Opcode, field and width definitions for the accumulator datapath.
`ifndef PPX_MAP_VH
`define PPX_MAP_VH

// ***************************************************************
// Widths and reset values
// ***************************************************************
`define PPX_ACC_W 18
`define PPX_WORD_W 12
`define PPX_FLD_W 6
`define PPX_ACC_RESET 18'h00000
`define PPX_WORD_RESET 12'h000

// ***************************************************************
// Addressing mode, taken from the upper octal digit of the opcode
// ***************************************************************
`define PPX_MODE_IMM 3'h1
`define PPX_MODE_CONST 3'h2
`define PPX_MODE_DIRECT 3'h3
`define PPX_MODE_INDIRECT 3'h4
`define PPX_MODE_INDEXED 3'h5

// ***************************************************************
// Function, taken from the lower octal digit in modes 3 to 5
// ***************************************************************
`define PPX_FN_SUB 3'h2
`define PPX_FN_XOR 3'h3
`define PPX_FN_RADD 3'h5
`define PPX_FN_INC 3'h6
`define PPX_FN_DEC 3'h7

// ***************************************************************
// Opcodes handled by this block
// ***************************************************************
`define PPX_OP_SHIFT_ACCUMULATOR 6'h08
`define PPX_OP_XOR_IMMEDIATE 6'h09
`define PPX_OP_AND_IMMEDIATE 6'h0a
`define PPX_OP_SELECTIVE_CLEAR 6'h0b
`define PPX_OP_SUB_IMMEDIATE 6'h0f
`define PPX_OP_AND_LONG_CONSTANT 6'h12
`define PPX_OP_XOR_LONG_CONSTANT 6'h13
`define PPX_OP_SUB_DIRECT 6'h1a
`define PPX_OP_XOR_DIRECT 6'h1b
`define PPX_OP_REPLACE_ADD_DIRECT 6'h1d
`define PPX_OP_INCREMENT_DIRECT 6'h1e
`define PPX_OP_DECREMENT_DIRECT 6'h1f
`define PPX_OP_SUB_INDIRECT 6'h22
`define PPX_OP_XOR_INDIRECT 6'h23
`define PPX_OP_REPLACE_ADD_INDIRECT 6'h25
`define PPX_OP_INCREMENT_INDIRECT 6'h26
`define PPX_OP_DECREMENT_INDIRECT 6'h27
`define PPX_OP_SUB_INDEXED 6'h2a
`define PPX_OP_XOR_INDEXED 6'h2b
`define PPX_OP_REPLACE_ADD_INDEXED 6'h2d
`define PPX_OP_INCREMENT_INDEXED 6'h2e
`define PPX_OP_DECREMENT_INDEXED 6'h2f

// ***************************************************************
// Arithmetic constants
// ***************************************************************
`define PPX_PLUS_ONE 18'h00001
`define PPX_MINUS_ONE 18'h3fffe
`define PPX_ROT_MOD 5'h12
`define PPX_STEP_ONE 12'h001
`define PPX_STEP_TWO 12'h002

`endif

// >>> hw/ppx_ones_add.v
// One's complement adder with end-around carry.
`timescale 1ns/100ps

module ppx_ones_add
#(
   parameter WIDTH = 18
)
(
   input wire [WIDTH-1:0] addA,
   input wire [WIDTH-1:0] addB,
   output wire [WIDTH-1:0] sum
);

   wire [WIDTH:0] rawSum;

   // Plain binary sum with the carry kept one bit above.
   assign rawSum = {1'b0, addA} + {1'b0, addB};

   // The carry out is folded back into bit zero, which is what makes it one's complement.
   assign sum = rawSum[WIDTH-1:0] + {{(WIDTH-1){1'b0}}, rawSum[WIDTH]};

endmodule

// >>> hw/ppx_alu.v
// Accumulator datapath for the subtract, logical and replace instruction groups.
`timescale 1ns/100ps
`include "ppx_map.vh"

// Operation
// - Opcode 17 subtracts the zero-extended 6-bit field from the accumulator.
// - Opcode 32 subtracts the word at field address, taken positive.
// - Opcode 42 reads a pointer at field address, subtracts the pointed word.
// - Indexed address is base word at P+1, plus word at field unless field is zero.
// - Opcode 10 rotates left for 00-37, shifts right end-off by complement otherwise.
// - Opcode 13 clears low accumulator bits where field bits are one.
// - Opcode 11 xors field into low six accumulator bits.
// - Opcode 23 xors accumulator with field and following word as 18 bits.
// - Opcode 33 xors the direct word into the low 12 accumulator bits.
// - Opcode 43 xors the indirect word into the low 12 accumulator bits.
// - Opcode 53 xors the indexed word into the low 12 accumulator bits.
// - Opcode 12 ands field with low six bits, upper twelve bits become zero.
// - Opcode 22 ands accumulator with field and following word as 18 bits.
// - Replace keeps 18-bit result in accumulator, stores only its rightmost bits.
// - Replace operands are one's complement and added in one's complement.
// - Opcode 35 adds direct word to accumulator and stores sum back.
// - Opcode 36 increments the direct word, stores it, accumulator gets it.
// - Opcode 45 adds indirect word to accumulator and stores sum back.
// - Opcode 46 increments the indirect word, stores it, accumulator gets it.
// - Opcode 55 adds indexed word to accumulator and stores sum back.
// - Opcode 56 increments the indexed word, stores it, accumulator gets it.
// - Opcodes 37, 47, 57 decrement direct, indirect, indexed words and store them.
// - Subtraction works in one's complement and replaces the accumulator.
// - Decrement leaves its result in the accumulator, old contents lost.
module ppx_alu
(
   input wire mclk,
   input wire rst_n,
   input wire start,
   input wire [`PPX_FLD_W-1:0] opcode,
   input wire [`PPX_FLD_W-1:0] dField,
   input wire [`PPX_WORD_W-1:0] progAddr,
   input wire accLoad,
   input wire [`PPX_ACC_W-1:0] accLoadValue,
   input wire memAck,
   input wire [`PPX_WORD_W-1:0] memRdata,
   output reg busy_ff,
   output reg done_ff,
   output reg badOp_ff,
   output reg [`PPX_ACC_W-1:0] acc_ff,
   output reg [`PPX_WORD_W-1:0] nextProg_ff,
   output reg memRd_ff,
   output reg memWr_ff,
   output reg [`PPX_WORD_W-1:0] memAddr_ff,
   output reg [`PPX_WORD_W-1:0] memWdata_ff
);

   // ***************************************************************
   // States
   // ***************************************************************
   localparam ST_IDLE = 3'h0;
   localparam ST_BASE = 3'h1;
   localparam ST_INDEX = 3'h2;
   localparam ST_POINT = 3'h3;
   localparam ST_OPND = 3'h4;
   localparam ST_EXEC = 3'h5;
   localparam ST_STORE = 3'h6;

   reg rstSync1_ff;
   reg rstSync2_ff;
   wire rstN;
   reg [2:0] state_ff;
   reg [`PPX_FLD_W-1:0] opc_ff;
   reg [`PPX_FLD_W-1:0] dFld_ff;
   reg [`PPX_WORD_W-1:0] prog_ff;
   reg [`PPX_WORD_W-1:0] base_ff;
   reg [`PPX_WORD_W-1:0] opnd_ff;
   reg [`PPX_WORD_W-1:0] opAddr_ff;
   reg legal_ff;
   wire [2:0] mode;
   wire [2:0] fn;
   wire [2:0] inMode;
   wire inLegal;
   wire isReplace;
   wire twoWord;
   wire [`PPX_ACC_W-1:0] longConst;
   wire [`PPX_ACC_W-1:0] opndWide;
   wire [`PPX_ACC_W-1:0] fieldWide;
   wire [4:0] rotAmt;
   wire [2*`PPX_ACC_W-1:0] rotWide;
   wire [`PPX_ACC_W-1:0] rotLeft;
   wire [`PPX_ACC_W-1:0] shRight;
   wire [`PPX_ACC_W-1:0] addSum;
   reg [`PPX_ACC_W-1:0] addA;
   reg [`PPX_ACC_W-1:0] addB;
   reg [`PPX_ACC_W-1:0] nxt_acc;

   // ***************************************************************
   // Reset release
   // ***************************************************************

   // The external reset acts at once but is released through two flip-flops.
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rstSync1_ff <= 1'b0;
         rstSync2_ff <= 1'b0;
      end
      else
      begin
         rstSync1_ff <= 1'b1;
         rstSync2_ff <= rstSync1_ff;
      end
   end

   assign rstN = rstSync2_ff;

   // ***************************************************************
   // Decode
   // ***************************************************************

   // Returns one for every opcode that this datapath carries out.
   function legalOp;
      input [`PPX_FLD_W-1:0] op;
      begin
         case (op)
            `PPX_OP_SHIFT_ACCUMULATOR, `PPX_OP_XOR_IMMEDIATE, `PPX_OP_AND_IMMEDIATE,
            `PPX_OP_SELECTIVE_CLEAR, `PPX_OP_SUB_IMMEDIATE, `PPX_OP_AND_LONG_CONSTANT,
            `PPX_OP_XOR_LONG_CONSTANT, `PPX_OP_SUB_DIRECT, `PPX_OP_XOR_DIRECT,
            `PPX_OP_REPLACE_ADD_DIRECT, `PPX_OP_INCREMENT_DIRECT,
            `PPX_OP_DECREMENT_DIRECT, `PPX_OP_SUB_INDIRECT, `PPX_OP_XOR_INDIRECT,
            `PPX_OP_REPLACE_ADD_INDIRECT, `PPX_OP_INCREMENT_INDIRECT,
            `PPX_OP_DECREMENT_INDIRECT, `PPX_OP_SUB_INDEXED, `PPX_OP_XOR_INDEXED,
            `PPX_OP_REPLACE_ADD_INDEXED, `PPX_OP_INCREMENT_INDEXED,
            `PPX_OP_DECREMENT_INDEXED:
               legalOp = 1'b1;
            default:
               legalOp = 1'b0;
         endcase
      end
   endfunction

   // The upper octal digit gives the addressing mode, the lower one the function.
   assign mode = opc_ff[5:3];
   assign fn = opc_ff[2:0];
   assign inMode = opcode[5:3];
   assign inLegal = legalOp(opcode);

   // Replace forms are functions 5, 6 and 7 in the memory modes.
   assign isReplace = legal_ff && (mode >= `PPX_MODE_DIRECT) && (fn >= `PPX_FN_RADD);

   // Constant and indexed forms use the word at P+1 and so occupy two words.
   assign twoWord = legal_ff && ((mode == `PPX_MODE_CONST) || (mode == `PPX_MODE_INDEXED));

   // Operand forms widened to the accumulator.
   assign longConst = {dFld_ff, base_ff};
   assign opndWide = {6'h00, opnd_ff};
   assign fieldWide = {12'h000, dFld_ff};

   // ***************************************************************
   // Shifter
   // ***************************************************************

   // Left shifts are circular, so a count of 18 or more wraps round once.
   assign rotAmt = (dFld_ff[4:0] >= `PPX_ROT_MOD) ? (dFld_ff[4:0] - `PPX_ROT_MOD) :
                   dFld_ff[4:0];
   assign rotWide = {acc_ff, acc_ff} << rotAmt;
   assign rotLeft = rotWide[2*`PPX_ACC_W-1:`PPX_ACC_W];

   // Right shifts drop bits off the end and fill with zero, never with the sign.
   assign shRight = acc_ff >> (~dFld_ff);

   // ***************************************************************
   // Arithmetic
   // ***************************************************************

   // Chooses the adder inputs: subtraction adds the complement of the operand.
   always @*
   begin
      addA = acc_ff;
      addB = ~opndWide;
      case (fn)
         `PPX_FN_RADD:
         begin
            addB = opndWide;
         end
         `PPX_FN_INC:
         begin
            addA = opndWide;
            addB = `PPX_PLUS_ONE;
         end
         `PPX_FN_DEC:
         begin
            addA = opndWide;
            addB = `PPX_MINUS_ONE;
            if (mode == `PPX_MODE_IMM)
            begin
               addA = acc_ff;
               addB = ~fieldWide;
            end
         end
         default:
         begin
            addB = ~opndWide;
         end
      endcase
   end

   // One adder serves subtract, replace add, increment and decrement.
   ppx_ones_add #(
      .WIDTH(`PPX_ACC_W)
   ) u_add (
      .addA(addA),
      .addB(addB),
      .sum(addSum)
   );

   // ***************************************************************
   // Result select
   // ***************************************************************

   // Forms the new accumulator for the instruction held in the decode registers.
   always @*
   begin
      nxt_acc = acc_ff;
      if (legal_ff)
      begin
         case (opc_ff)
            `PPX_OP_SHIFT_ACCUMULATOR:
               nxt_acc = dFld_ff[5] ? shRight : rotLeft;
            `PPX_OP_SELECTIVE_CLEAR:
               nxt_acc = {acc_ff[17:6], acc_ff[5:0] & ~dFld_ff};
            `PPX_OP_XOR_IMMEDIATE:
               nxt_acc = {acc_ff[17:6], acc_ff[5:0] ^ dFld_ff};
            `PPX_OP_AND_IMMEDIATE:
               nxt_acc = {12'h000, acc_ff[5:0] & dFld_ff};
            `PPX_OP_XOR_LONG_CONSTANT:
               nxt_acc = acc_ff ^ longConst;
            `PPX_OP_AND_LONG_CONSTANT:
               nxt_acc = acc_ff & longConst;
            `PPX_OP_XOR_DIRECT:
               nxt_acc = {acc_ff[17:12], acc_ff[11:0] ^ opnd_ff};
            `PPX_OP_XOR_INDIRECT:
               nxt_acc = {acc_ff[17:12], acc_ff[11:0] ^ opnd_ff};
            `PPX_OP_XOR_INDEXED:
               nxt_acc = {acc_ff[17:12], acc_ff[11:0] ^ opnd_ff};
            default:
               nxt_acc = addSum;
         endcase
      end
   end

   // ***************************************************************
   // Sequencer
   // ***************************************************************

   // Walks the operand fetches, executes, and writes back replace results.
   always @(posedge mclk or negedge rstN)
   begin
      if (!rstN)
      begin
         state_ff <= ST_IDLE;
         opc_ff <= 6'h00;
         dFld_ff <= 6'h00;
         prog_ff <= `PPX_WORD_RESET;
         base_ff <= `PPX_WORD_RESET;
         opnd_ff <= `PPX_WORD_RESET;
         opAddr_ff <= `PPX_WORD_RESET;
         legal_ff <= 1'b0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
         badOp_ff <= 1'b0;
         acc_ff <= `PPX_ACC_RESET;
         nextProg_ff <= `PPX_WORD_RESET;
         memRd_ff <= 1'b0;
         memWr_ff <= 1'b0;
         memAddr_ff <= `PPX_WORD_RESET;
         memWdata_ff <= `PPX_WORD_RESET;
      end
      else
      begin
         done_ff <= 1'b0;
         badOp_ff <= 1'b0;
         case (state_ff)
            ST_IDLE:
            begin
               if (start)
               begin
                  opc_ff <= opcode;
                  dFld_ff <= dField;
                  prog_ff <= progAddr;
                  legal_ff <= inLegal;
                  busy_ff <= 1'b1;
                  state_ff <= ST_EXEC;
                  if (inLegal && (inMode == `PPX_MODE_CONST || inMode == `PPX_MODE_INDEXED))
                  begin
                     memRd_ff <= 1'b1;
                     memAddr_ff <= progAddr + `PPX_STEP_ONE;
                     state_ff <= ST_BASE;
                  end
                  else if (inLegal && inMode == `PPX_MODE_DIRECT)
                  begin
                     memRd_ff <= 1'b1;
                     memAddr_ff <= {6'h00, dField};
                     opAddr_ff <= {6'h00, dField};
                     state_ff <= ST_OPND;
                  end
                  else if (inLegal && inMode == `PPX_MODE_INDIRECT)
                  begin
                     memRd_ff <= 1'b1;
                     memAddr_ff <= {6'h00, dField};
                     state_ff <= ST_POINT;
                  end
               end
               else if (accLoad)
               begin
                  acc_ff <= accLoadValue;
               end
            end
            ST_BASE:
            begin
               if (memAck)
               begin
                  base_ff <= memRdata;
                  memRd_ff <= 1'b0;
                  state_ff <= ST_EXEC;
                  if (mode == `PPX_MODE_INDEXED && dFld_ff == 6'h00)
                  begin
                     memRd_ff <= 1'b1;
                     memAddr_ff <= memRdata;
                     opAddr_ff <= memRdata;
                     state_ff <= ST_OPND;
                  end
                  else if (mode == `PPX_MODE_INDEXED)
                  begin
                     memRd_ff <= 1'b1;
                     memAddr_ff <= {6'h00, dFld_ff};
                     state_ff <= ST_INDEX;
                  end
               end
            end
            ST_INDEX:
            begin
               if (memAck)
               begin
                  memAddr_ff <= base_ff + memRdata;
                  opAddr_ff <= base_ff + memRdata;
                  state_ff <= ST_OPND;
               end
            end
            ST_POINT:
            begin
               if (memAck)
               begin
                  memAddr_ff <= memRdata;
                  opAddr_ff <= memRdata;
                  state_ff <= ST_OPND;
               end
            end
            ST_OPND:
            begin
               if (memAck)
               begin
                  opnd_ff <= memRdata;
                  memRd_ff <= 1'b0;
                  state_ff <= ST_EXEC;
               end
            end
            ST_EXEC:
            begin
               acc_ff <= nxt_acc;
               if (isReplace)
               begin
                  memWr_ff <= 1'b1;
                  memAddr_ff <= opAddr_ff;
                  memWdata_ff <= nxt_acc[`PPX_WORD_W-1:0];
                  state_ff <= ST_STORE;
               end
               else
               begin
                  busy_ff <= 1'b0;
                  done_ff <= 1'b1;
                  badOp_ff <= ~legal_ff;
                  nextProg_ff <= prog_ff + (twoWord ? `PPX_STEP_TWO : `PPX_STEP_ONE);
                  state_ff <= ST_IDLE;
               end
            end
            ST_STORE:
            begin
               if (memAck)
               begin
                  memWr_ff <= 1'b0;
                  busy_ff <= 1'b0;
                  done_ff <= 1'b1;
                  nextProg_ff <= prog_ff + (twoWord ? `PPX_STEP_TWO : `PPX_STEP_ONE);
                  state_ff <= ST_IDLE;
               end
            end
            default:
            begin
               memRd_ff <= 1'b0;
               memWr_ff <= 1'b0;
               busy_ff <= 1'b0;
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

endmodule

// >>> test/ppx_alu_asserts.sv
// Concurrent checks on the ports of the accumulator datapath.
`timescale 1ns/100ps

// ***********************************************
// Checker module
// ***********************************************
module ppx_alu_asserts
(
   input wire mclk,
   input wire rst_n,
   input wire start,
   input wire [5:0] opcode,
   input wire [5:0] dField,
   input wire [11:0] progAddr,
   input wire accLoad,
   input wire [17:0] accLoadValue,
   input wire memAck,
   input wire [11:0] memRdata,
   input wire busy_ff,
   input wire done_ff,
   input wire badOp_ff,
   input wire [17:0] acc_ff,
   input wire [11:0] nextProg_ff,
   input wire memRd_ff,
   input wire memWr_ff,
   input wire [11:0] memAddr_ff,
   input wire [11:0] memWdata_ff
);
   reg [17:0] accS;
   reg [5:0] opS;
   reg [5:0] dS;
   reg [11:0] pS;
   wire twoW = (opS == 6'h12) || (opS == 6'h13) || (opS[5:3] == 3'h5);
   wire [18:0] subRaw = {1'b0, accS} + {1'b0, ~{12'h000, dS}};
   wire [17:0] subRes = subRaw[17:0] + {17'h00000, subRaw[18]};
   // Operands are captured at the edge that takes an instruction.
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         accS <= 18'h00000;
         opS <= 6'h00;
         dS <= 6'h00;
         pS <= 12'h000;
      end
      else if (start && !busy_ff)
      begin
         accS <= acc_ff;
         opS <= opcode;
         dS <= dField;
         pS <= progAddr;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   imm_sub_a: assert property (done_ff && opS == 6'h0f |-> acc_ff == subRes)
      else $error("immediate subtract result wrong");
   imm_xor_a: assert property (done_ff && opS == 6'h09 |->
      acc_ff == (accS ^ {12'h000, dS}))
      else $error("immediate xor result wrong");
   imm_and_a: assert property (done_ff && opS == 6'h0a |->
      acc_ff == {12'h000, accS[5:0] & dS})
      else $error("immediate and result wrong");
   sel_clear_a: assert property (done_ff && opS == 6'h0b |->
      acc_ff == {accS[17:6], accS[5:0] & ~dS})
      else $error("selective clear result wrong");
   next_addr_a: assert property (done_ff && !badOp_ff |->
      nextProg_ff == pS + (twoW ? 12'h002 : 12'h001))
      else $error("next program address wrong");
   wr_data_a: assert property (memWr_ff |-> memWdata_ff == acc_ff[11:0])
      else $error("stored word is not the low accumulator bits");
   wr_hold_a: assert property (memWr_ff && !memAck |=>
      memWr_ff && $stable(memAddr_ff) && $stable(memWdata_ff))
      else $error("write request dropped before answer");
   rd_hold_a: assert property (memRd_ff && !memAck |=> memRd_ff && $stable(memAddr_ff))
      else $error("read request dropped before answer");
   done_pulse_a: assert property (done_ff |=> !done_ff)
      else $error("completion longer than one cycle");
endmodule

bind ppx_alu ppx_alu_asserts chk (.mclk(mclk), .rst_n(rst_n), .start(start),
   .opcode(opcode), .dField(dField), .progAddr(progAddr), .accLoad(accLoad),
   .accLoadValue(accLoadValue), .memAck(memAck), .memRdata(memRdata), .busy_ff(busy_ff),
   .done_ff(done_ff), .badOp_ff(badOp_ff), .acc_ff(acc_ff), .nextProg_ff(nextProg_ff),
   .memRd_ff(memRd_ff), .memWr_ff(memWr_ff), .memAddr_ff(memAddr_ff),
   .memWdata_ff(memWdata_ff));

// >>> test/ppx_mem_model.sv
// Behavioural local memory that answers the datapath's requests.
`timescale 1ns/100ps

// ***********************************************
// Memory model
// ***********************************************
module ppx_mem_model
(
   input wire mclk,
   input wire slow,
   input wire memRd,
   input wire memWr,
   input wire [11:0] memAddr,
   input wire [11:0] memWdata,
   output wire memAck,
   output wire [11:0] memRdata
);
   reg [11:0] mem [0:4095];
   reg [11:0] lastRd_ff = 12'h000;
   reg waited_ff = 1'b0;
   // A slow memory lets one cycle of every request pass before it answers.
   assign memAck = (memRd || memWr) && (!slow || waited_ff);
   // Outside an answered read the lines show the inverse of the last word.
   assign memRdata = (memAck && memRd) ? mem[memAddr] : ~lastRd_ff;
   // Requests complete on the edge that sees the answer.
   always @(posedge mclk)
   begin
      waited_ff <= (memRd || memWr) && !memAck;
      if (memAck && memRd)
         lastRd_ff <= mem[memAddr];
      if (memAck && memWr)
         mem[memAddr] <= memWdata;
   end
endmodule

// >>> test/testbench.sv
// Self-checking bench for the accumulator datapath.
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests = n_tests + 1; if ((g) !== (e)) \
   begin mismatches = mismatches + 1; $display("BAD %0t got %h want %h", $time, g, e); end end

// ***********************************************
// Bench top
// ***********************************************
module testbench;
   reg mclk, rst_n, start, accLoad, slow;
   reg [5:0] opcode, dField;
   reg [11:0] progAddr;
   reg [17:0] accLoadValue;
   wire memAck, busy_ff, done_ff, badOp_ff, memRd_ff, memWr_ff;
   wire [11:0] memRdata, nextProg_ff, memAddr_ff, memWdata_ff;
   wire [17:0] acc_ff;
   integer mismatches, n_tests;
   // High while the instruction under test is one the datapath must refuse.
   reg expBad;
   ppx_alu DUT (.mclk(mclk), .rst_n(rst_n), .start(start), .opcode(opcode), .dField(dField),
      .progAddr(progAddr), .accLoad(accLoad), .accLoadValue(accLoadValue), .memAck(memAck),
      .memRdata(memRdata), .busy_ff(busy_ff), .done_ff(done_ff), .badOp_ff(badOp_ff),
      .acc_ff(acc_ff), .nextProg_ff(nextProg_ff), .memRd_ff(memRd_ff), .memWr_ff(memWr_ff),
      .memAddr_ff(memAddr_ff), .memWdata_ff(memWdata_ff));
   ppx_mem_model MEM (.mclk(mclk), .slow(slow), .memRd(memRd_ff), .memWr(memWr_ff),
      .memAddr(memAddr_ff), .memWdata(memWdata_ff), .memAck(memAck), .memRdata(memRdata));
   // One's complement sum with end-around carry.
   function [17:0] oc(input [17:0] a, input [17:0] b);
      reg [18:0] s;
      begin
         s = a + b;
         oc = s[17:0] + s[18];
      end
   endfunction
   // Words at 5, 40, 101, 200, 240; word 0 would mislead a wrong zero index.
   task layout;
      begin
         MEM.mem[12'h000] = 12'h010;
         MEM.mem[12'h005] = 12'h040;
         MEM.mem[12'h040] = 12'h321;
         MEM.mem[12'h101] = 12'h200;
         MEM.mem[12'h200] = 12'h055;
         MEM.mem[12'h240] = 12'h0ab;
      end
   endtask
   // Presets the accumulator, runs one instruction at address 100 and checks it.
   task run(input [5:0] op, input [5:0] d, input [17:0] a0, input [17:0] ea, input two);
      integer i;
      begin
         @(negedge mclk);
         accLoad = 1;
         accLoadValue = a0;
         @(negedge mclk);
         accLoad = 0;
         start = 1;
         opcode = op;
         dField = d;
         @(negedge mclk);
         start = 0;
         i = 0;
         while (done_ff !== 1'b1 && i < 40)
         begin
            @(negedge mclk);
            i = i + 1;
         end
         `CHK(done_ff, 1'b1)
         `CHK(busy_ff, 1'b0)
         `CHK(acc_ff, ea)
         `CHK(nextProg_ff, progAddr + (two ? 12'h002 : 12'h001))
         `CHK(badOp_ff, expBad)
      end
   endtask
   // Runs a replace instruction and checks the stored word, then restores memory.
   task rep(input [5:0] op, input [5:0] d, input [17:0] a0, input [17:0] ea,
      input [11:0] ad, input two);
      begin
         run(op, d, a0, ea, two);
         `CHK(MEM.mem[ad], ea[11:0])
         layout;
      end
   endtask
   task t_sub;
      begin
         run(6'h0f, 6'h05, 18'h00100, oc(18'h00100, ~18'h00005), 0);
         run(6'h0f, 6'h00, 18'h00000, 18'h3ffff, 0);
         run(6'h1a, 6'h05, 18'h00100, oc(18'h00100, ~18'h00040), 0);
         run(6'h22, 6'h05, 18'h00100, oc(18'h00100, ~18'h00321), 0);
         run(6'h2a, 6'h05, 18'h00100, oc(18'h00100, ~18'h000ab), 1);
         run(6'h2a, 6'h00, 18'h00100, oc(18'h00100, ~18'h00055), 1);
      end
   endtask
   task t_shift;
      begin
         run(6'h08, 6'h06, 18'h20001, 18'h00060, 0);
         run(6'h08, 6'h11, 18'h20001, 18'h30000, 0);
         run(6'h08, 6'h39, 18'h20001, 18'h00800, 0);
         run(6'h08, 6'h14, 18'h20001, 18'h00006, 0);
         run(6'h08, 6'h3f, 18'h20001, 18'h20001, 0);
      end
   endtask
   task t_logic;
      begin
         run(6'h0b, 6'h3f, 18'h2aaaa, 18'h2aa80, 0);
         run(6'h09, 6'h3f, 18'h2aaaa, 18'h2aa95, 0);
         run(6'h0a, 6'h0f, 18'h2aaaa, 18'h0000a, 0);
         run(6'h13, 6'h3f, 18'h2aaaa, 18'h2aaaa ^ 18'h3f200, 1);
         run(6'h12, 6'h2a, 18'h2aaaa, 18'h2aaaa & 18'h2a200, 1);
         expBad = 1;
         run(6'h0e, 6'h05, 18'h2aaaa, 18'h2aaaa, 0);
         expBad = 0;
      end
   endtask
   // Memory xor forms against a slow memory.
   task t_xor;
      begin
         slow = 1;
         run(6'h1b, 6'h05, 18'h3f000, 18'h3f040, 0);
         run(6'h23, 6'h05, 18'h3f000, 18'h3f321, 0);
         run(6'h2b, 6'h05, 18'h3f000, 18'h3f0ab, 1);
         slow = 0;
      end
   endtask
   task t_rep;
      begin
         rep(6'h1d, 6'h05, 18'h3fffe, 18'h0003f, 12'h005, 0);
         rep(6'h1d, 6'h05, 18'h00fff, 18'h0103f, 12'h005, 0);
         rep(6'h1e, 6'h05, 18'h12345, 18'h00041, 12'h005, 0);
         rep(6'h1f, 6'h05, 18'h12345, 18'h0003f, 12'h005, 0);
         slow = 1;
         rep(6'h25, 6'h05, 18'h00100, oc(18'h00100, 18'h00321), 12'h040, 0);
         rep(6'h26, 6'h05, 18'h12345, 18'h00322, 12'h040, 0);
         rep(6'h27, 6'h05, 18'h12345, 18'h00320, 12'h040, 0);
         slow = 0;
         rep(6'h2d, 6'h05, 18'h00100, 18'h001ab, 12'h240, 1);
         rep(6'h2e, 6'h05, 18'h12345, 18'h000ac, 12'h240, 1);
         rep(6'h2f, 6'h00, 18'h12345, 18'h00054, 12'h200, 1);
      end
   endtask
   task stop_test;
      begin
         $display("mismatches %0d n_tests %0d", mismatches, n_tests);
         if (mismatches == 0 && n_tests > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   // Free-running 50 MHz clock.
   initial
   begin
      mclk = 0;
      forever #10 mclk = ~mclk;
   end
   // Watchdog cuts a hang well beyond the expected run length.
   initial
   begin
      #100000;
      mismatches = mismatches + 1;
      stop_test;
   end
   // Main sequence: reset, then every scenario in turn.
   initial
   begin
      rst_n = 0;
      start = 0;
      accLoad = 0;
      slow = 0;
      expBad = 0;
      opcode = 6'h00;
      dField = 6'h00;
      progAddr = 12'h100;
      accLoadValue = 18'h00000;
      mismatches = 0;
      n_tests = 0;
      layout;
      repeat (5) @(negedge mclk);
      rst_n = 1;
      repeat (3) @(negedge mclk);
      t_sub;
      t_shift;
      t_logic;
      t_xor;
      t_rep;
      stop_test;
   end
endmodule
